// file: core/tscb_pkg.sv
package tscb_pkg;

  // address map, byte offsets inside the 4KB block
  localparam logic [11:0] OFS_STIM_LO      = 12'h000;
  localparam logic [11:0] OFS_STIM_HI      = 12'h07C;
  localparam logic [11:0] OFS_IMPL_LO      = 12'hA00;
  localparam logic [11:0] OFS_IMPL_HI      = 12'hDFC;
  localparam logic [11:0] OFS_TRACE_EN     = 12'hE00;
  localparam logic [11:0] OFS_TRIG_EN      = 12'hE20;
  localparam logic [11:0] OFS_PRIV_MASK    = 12'hE40;
  localparam logic [11:0] OFS_GROUP_SEL    = 12'hE60;
  localparam logic [11:0] OFS_MASTER_SEL   = 12'hE64;
  localparam logic [11:0] OFS_PORT_OVR     = 12'hE68;
  localparam logic [11:0] OFS_MASTER_OVR   = 12'hE6C;
  localparam logic [11:0] OFS_TRIG_CSR     = 12'hE70;
  localparam logic [11:0] OFS_TRACE_CSR    = 12'hE80;
  localparam logic [11:0] OFS_TS_REQ       = 12'hE84;
  localparam logic [11:0] OFS_TS_FREQ      = 12'hE8C;
  localparam logic [11:0] OFS_SYNC         = 12'hE90;
  localparam logic [11:0] OFS_AUX          = 12'hE94;
  localparam logic [11:0] OFS_FEAT1        = 12'hEA0;
  localparam logic [11:0] OFS_FEAT2        = 12'hEA4;
  localparam logic [11:0] OFS_FEAT3        = 12'hEA8;
  localparam logic [11:0] OFS_ITCTRL       = 12'hF00;
  localparam logic [11:0] OFS_CLAIM_SET    = 12'hFA0;
  localparam logic [11:0] OFS_CLAIM_CLR    = 12'hFA4;
  localparam logic [11:0] OFS_UNLOCK       = 12'hFB0;
  localparam logic [11:0] OFS_LOCK_STATE   = 12'hFB4;
  localparam logic [11:0] OFS_AUTH         = 12'hFB8;
  localparam logic [11:0] OFS_ARCH         = 12'hFBC;
  localparam logic [11:0] OFS_DEVCFG       = 12'hFC8;
  localparam logic [11:0] OFS_DEVKIND      = 12'hFCC;

  // structure constants
  localparam int          NUM_PORTS        = 32;
  localparam int          PORT_W           = 5;
  localparam int          PRIV_W           = 4;
  localparam int          CLAIM_W          = 4;

  // field positions
  localparam int          SEL_CTL_LSB      = 0;
  localparam int          SEL_FIELD_LSB    = 20;
  localparam int          SEL_FIELD_W      = 12;
  localparam int          FEAT2_STIM_BIT   = 0;
  localparam int          FEAT2_TRIG_BIT   = 1;
  localparam int          LOCK_IMPL_BIT    = 0;
  localparam int          LOCK_SET_BIT     = 1;
  localparam int          TCSR_EN_BIT      = 0;

  // reset values and codes
  localparam logic [31:0] RST_ZERO         = 32'h0000_0000;
  localparam logic [1:0]  CTL_NOT_USED     = 2'h0;
  localparam logic [1:0]  CTL_BOTH         = 2'h3;
  localparam logic [31:0] UNLOCK_KEY       = 32'h0000_1234; // arbitrary key value
  localparam logic [31:0] ARCH_ID          = 32'h0000_0000; // arbitrary value
  localparam logic [31:0] KIND_ID          = 32'h0000_0000; // arbitrary value

  // one request from the bus slave to the register file
  typedef struct packed {
    logic        wr;
    logic [11:0] offs;
    logic [31:0] wdata;
  } tscb_req_s;

  // one stimulus event towards the trace path
  typedef struct packed {
    logic              valid;
    logic [PORT_W-1:0] port;
    logic [31:0]       data;
    logic              trig;
  } tscb_evt_s;

  typedef enum logic [1:0] {
    TSCB_IDLE = 2'b01,
    TSCB_DATA = 2'b10
  } tscb_phase_e;

endpackage : tscb_pkg

// file: core/tscb_ahb_slave.sv
`timescale 1ns/10ps
module tscb_ahb_slave
  import tscb_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] rd_value,
  output logic [11:0]      ap_offs,
  output tscb_req_s        req,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp
);

  tscb_phase_e phase;
  logic        dp_wr;
  logic [11:0] dp_offs;

  // a transfer is taken on NONSEQ or SEQ while the bus is ready
  wire take = hsel & htrans[1] & hready;
  assign ap_offs = {haddr[11:2], 2'b00};

  // write data only stands in the data phase, so the store happens then
  assign req.wr    = (phase == TSCB_DATA) & dp_wr;
  assign req.offs  = dp_offs;
  assign req.wdata = hwdata;

  // phase tracker; zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase     <= TSCB_IDLE;
      dp_wr     <= 1'b0;
      dp_offs   <= 12'h000;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      phase   <= take ? TSCB_DATA : TSCB_IDLE;
      dp_wr   <= take & hwrite;
      dp_offs <= ap_offs;
      // read data is sampled from the address phase value
      if (take && !hwrite) begin
        hrdata <= rd_value;
      end
    end
  end

endmodule : tscb_ahb_slave

// file: core/tscb_stim_path.sv
`timescale 1ns/10ps
module tscb_stim_path
  import tscb_pkg::*;
(
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 wr_stb,
  input  wire logic [PORT_W-1:0]    wr_port,
  input  wire logic [31:0]          wr_data,
  input  wire logic [NUM_PORTS-1:0] trace_en,
  input  wire logic [NUM_PORTS-1:0] trig_en,
  input  wire logic                 sink_ready,
  input  wire logic [PORT_W-1:0]    rd_port,
  output logic                      rd_ready,
  output tscb_evt_s                 evt
);

  wire accept = wr_stb & trace_en[wr_port] & sink_ready;
  assign rd_ready = trace_en[rd_port] & sink_ready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt <= '0;
    end else begin
      evt.valid <= accept;
      if (accept) begin
        evt.port <= wr_port;
        evt.data <= wr_data;
        evt.trig <= trig_en[wr_port];
      end
    end
  end

endmodule : tscb_stim_path

// file: core/tscb_top.sv
`timescale 1ns/10ps
// Behaviour
// - registers decoded in one 4KB block
// - reserved reads zero, writes ignored
// - unspecified registers may reset arbitrarily
// - 32 basic ports at 0x000-0x07C
// - basic write equals master 0 timestamped
// - stimulus ports ignore the lock
// - bit 0 reads write acceptance
// - trace enable mask at 0xE00, resets 0
// - mask width equals port count
// - bit 0 is lowest numbered port
// - trace mask always, trigger mask optional
// - trigger mask at 0xE20, resets 0
// - trigger mask width equals port count
// - trigger mask readback proves presence
// - feature two shows basic ports
// - control, status, ident, management groups
// - four implementation blocks 0xA00-0xDFC
// - select control 00 applies masks everywhere
module tscb_top
  import tscb_pkg::*;
#(
  parameter bit HAS_STIM = 1'b1,
  parameter bit HAS_TRIG = 1'b1
)
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic        sink_ready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output tscb_evt_s        stim_evt,
  output logic             trace_on,
  output logic             ts_request
);

  // all registers except the lock are reset to zero here; the zero is one legal choice
  logic [NUM_PORTS-1:0] port_enable_mask;
  logic [NUM_PORTS-1:0] trigger_enable_mask;
  logic [PRIV_W-1:0]    user_access_mask;
  logic [31:0]          port_group_select;
  logic [31:0]          trace_ctrl_status;
  logic [31:0]          timestamp_frequency;
  logic [31:0]          sync_control;
  logic [31:0]          auxiliary_control;
  logic [CLAIM_W-1:0]   claim_tag;
  logic                 locked;
  logic [31:0]          impl_store [4];

  // bus side view: req is the transfer in its data phase, ap_offs the one in its address phase
  tscb_req_s            req;
  logic [11:0]          ap_offs;
  logic [31:0]          rd_value;
  logic                 rd_ready;

  // lowest set bit marks the group mask; group 0 is covered when the
  // bits above it are all zero
  function automatic logic covers_group0(input logic [SEL_FIELD_W-1:0] sel);
    logic [SEL_FIELD_W-1:0] low;
    logic [SEL_FIELD_W-1:0] above;
    low   = sel & (~sel + 1'b1);
    above = sel & ~(low | (low - 1'b1));
    return (sel != '0) && (above == '0);
  endfunction : covers_group0

  // offset range test used across the decode
  function automatic logic in_range(input logic [11:0] a,
                                    input logic [11:0] lo,
                                    input logic [11:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction : in_range

  // only the low 12 address bits select a register
  wire is_stim_w   = in_range(req.offs, OFS_STIM_LO, OFS_STIM_HI) & HAS_STIM;
  wire is_impl_w   = in_range(req.offs, OFS_IMPL_LO, OFS_IMPL_HI);
  // narrow transfers are dropped rather than merged, so no mask is half written
  wire word_access = (hsize == 3'h2);
  // read-side range hits; the stimulus read answers with the ready bit only
  wire rd_stim_w   = in_range(ap_offs, OFS_STIM_LO, OFS_STIM_HI) & HAS_STIM;
  wire rd_impl_w   = in_range(ap_offs, OFS_IMPL_LO, OFS_IMPL_HI);
  wire rd_claim_w  = (ap_offs == OFS_CLAIM_SET) | (ap_offs == OFS_CLAIM_CLR);

  // a locked bank still answers every read; only stores are held back
  // stimulus writes skip the lock gate
  wire cfg_wr      = req.wr & ~locked;
  wire wr_trace_en = cfg_wr & (req.offs == OFS_TRACE_EN);
  wire wr_trig_en  = cfg_wr & (req.offs == OFS_TRIG_EN) & HAS_TRIG;
  wire wr_priv     = cfg_wr & (req.offs == OFS_PRIV_MASK);
  wire wr_grp      = cfg_wr & (req.offs == OFS_GROUP_SEL);
  wire wr_tcsr     = cfg_wr & (req.offs == OFS_TRACE_CSR);
  wire wr_ts       = cfg_wr & (req.offs == OFS_TS_REQ);
  wire wr_freq     = cfg_wr & (req.offs == OFS_TS_FREQ);
  wire wr_sync     = cfg_wr & (req.offs == OFS_SYNC);
  wire wr_aux      = cfg_wr & (req.offs == OFS_AUX);
  wire wr_cset     = cfg_wr & (req.offs == OFS_CLAIM_SET);
  wire wr_cclr     = cfg_wr & (req.offs == OFS_CLAIM_CLR);
  wire wr_impl     = cfg_wr & is_impl_w;
  // the unlock register itself must stay writable while locked
  wire wr_unlock   = req.wr & (req.offs == OFS_UNLOCK);
  wire wr_stim     = req.wr & is_stim_w;

  // select control 00 ignores the field
  wire [1:0]             sel_ctl  = port_group_select[SEL_CTL_LSB +: 2];
  wire [SEL_FIELD_W-1:0] sel_fld  = port_group_select[SEL_FIELD_LSB +: SEL_FIELD_W];
  wire                   grp0_hit = covers_group0(sel_fld);

  // only group 0 exists here, so each gate is a single bit that is
  // spread over all 32 ports
  wire trace_gate = (sel_ctl != CTL_BOTH) | grp0_hit;
  wire trig_gate  = (sel_ctl == CTL_NOT_USED) | grp0_hit;
  // with 32 ports the mask maps straight onto them
  wire [NUM_PORTS-1:0] eff_trace = port_enable_mask & {NUM_PORTS{trace_gate}};
  // trigger follows the selection unless control is 00
  wire [NUM_PORTS-1:0] eff_trig  = trigger_enable_mask & {NUM_PORTS{trig_gate}};

  // parameters fix the optional parts, so feature two never changes at run time
  // feature two advertises the optional parts
  wire [31:0] feat2 = (32'(HAS_STIM) << FEAT2_STIM_BIT) |
                      (32'(HAS_TRIG) << FEAT2_TRIG_BIT);
  // the implemented bit is fixed high so software can probe for the lock
  wire [31:0] lock_state = (32'h1 << LOCK_IMPL_BIT) | (32'(locked) << LOCK_SET_BIT);

  // read decode over the register groups
  always_comb begin
    rd_value = RST_ZERO;
    // ready is taken at the address edge; a stall that starts one cycle
    // later still drops the write that follows
    // ready in bit 0 only
    if (rd_stim_w) begin
      rd_value = {31'h0, rd_ready};
    end else if (rd_impl_w) begin
      rd_value = impl_store[ap_offs[9:8]];
    end else if (ap_offs == OFS_TRACE_EN) begin
      rd_value = port_enable_mask;
    end else if (ap_offs == OFS_TRIG_EN) begin
      rd_value = HAS_TRIG ? trigger_enable_mask : RST_ZERO;
    end else if (ap_offs == OFS_PRIV_MASK) begin
      rd_value = {28'h0, user_access_mask};
    end else if (ap_offs == OFS_GROUP_SEL) begin
      rd_value = port_group_select;
    end else if (ap_offs == OFS_TRACE_CSR) begin
      rd_value = trace_ctrl_status;
    end else if (ap_offs == OFS_TS_FREQ) begin
      rd_value = timestamp_frequency;
    end else if (ap_offs == OFS_SYNC) begin
      rd_value = sync_control;
    end else if (ap_offs == OFS_AUX) begin
      rd_value = auxiliary_control;
    end else if (ap_offs == OFS_FEAT2) begin
      rd_value = feat2;
    end else if (rd_claim_w) begin
      rd_value = {28'h0, claim_tag};
    end else if (ap_offs == OFS_LOCK_STATE) begin
      rd_value = lock_state;
    end else if (ap_offs == OFS_ARCH) begin
      rd_value = ARCH_ID;
    end else if (ap_offs == OFS_DEVKIND) begin
      rd_value = KIND_ID;
    // zero is one legal choice for unknown data and keeps reads repeatable
    // reserved and unlisted offsets read zero
    end else begin
      rd_value = RST_ZERO;
    end
  end

  // limitation: read data is fetched at the address edge, so a read issued
  // straight behind a write to the same register returns the old value;
  // masters leave one idle cycle between the two
  // bus slave; sub-word transfers are not expected on this bank
  tscb_ahb_slave u_slave (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel & word_access),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hwdata    (hwdata),
    .hready    (hready),
    .rd_value  (rd_value),
    .ap_offs   (ap_offs),
    .req       (req),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp)
  );

  tscb_stim_path u_stim (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .wr_stb     (wr_stim),
    .wr_port    (req.offs[6:2]),
    .wr_data    (req.wdata),
    .trace_en   (eff_trace),
    .trig_en    (eff_trig),
    .sink_ready (sink_ready),
    .rd_port    (ap_offs[6:2]),
    .rd_ready   (rd_ready),
    .evt        (stim_evt)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_enable_mask <= '0;
    end else if (wr_trace_en) begin
      port_enable_mask <= req.wdata[NUM_PORTS-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trigger_enable_mask <= '0;
    end else if (wr_trig_en) begin
      trigger_enable_mask <= req.wdata[NUM_PORTS-1:0];
    end
  end

  // one bit covers eight ports, so 32 ports need only four bits
  // user access mask is kept for software; gating lives elsewhere
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      user_access_mask <= '0;
    end else if (wr_priv) begin
      user_access_mask <= req.wdata[PRIV_W-1:0];
    end
  end

  // group select, control resets to 00
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_group_select <= RST_ZERO;
    end else if (wr_grp) begin
      port_group_select <= req.wdata;
    end
  end

  // trace control store
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trace_ctrl_status <= RST_ZERO;
    end else if (wr_tcsr) begin
      trace_ctrl_status <= req.wdata;
    end
  end

  // enable output takes the written value at the same edge, so it never
  // lags the register by a cycle
  wire next_trace_on = wr_tcsr ? req.wdata[TCSR_EN_BIT] : trace_ctrl_status[TCSR_EN_BIT];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trace_on <= 1'b0;
    end else begin
      trace_on <= next_trace_on;
    end
  end

  // timestamp request is write-only: a one-cycle pulse
  // nothing reads it back, so the pulse is the only trace of the write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ts_request <= 1'b0;
    end else begin
      ts_request <= wr_ts;
    end
  end

  // timestamp frequency store
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timestamp_frequency <= RST_ZERO;
    end else if (wr_freq) begin
      timestamp_frequency <= req.wdata;
    end
  end

  // sync control store
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_control <= RST_ZERO;
    end else if (wr_sync) begin
      sync_control <= req.wdata;
    end
  end

  // auxiliary control store
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      auxiliary_control <= RST_ZERO;
    end else if (wr_aux) begin
      auxiliary_control <= req.wdata;
    end
  end

  // claim tags: set and clear by ones; the two offsets never meet in one
  // transfer, so the order of the choice below is only a tie-break
  wire [CLAIM_W-1:0] claim_up       = claim_tag | req.wdata[CLAIM_W-1:0];
  wire [CLAIM_W-1:0] claim_dn       = claim_tag & ~req.wdata[CLAIM_W-1:0];
  wire [CLAIM_W-1:0] next_claim_tag = wr_cset ? claim_up : (wr_cclr ? claim_dn : claim_tag);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      claim_tag <= '0;
    end else begin
      claim_tag <= next_claim_tag;
    end
  end

  // lock starts set; the key opens it, any other value closes it
  // starting locked keeps stray boot-time writes away from the trace setup
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      locked <= 1'b1;
    end else if (wr_unlock) begin
      locked <= (req.wdata != UNLOCK_KEY);
    end
  end

  // every word of a block aliases onto that block's one scratch word
  // one scratch word per implementation block
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      impl_store <= '{default: RST_ZERO};
    end else if (wr_impl) begin
      impl_store[req.offs[9:8]] <= req.wdata;
    end
  end

endmodule : tscb_top

// file: testbench/tscb_top_monitor.sv
`timescale 1ns/10ps
module tscb_top_monitor
  import tscb_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        sink_ready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire tscb_evt_s   stim_evt,
  input wire logic        trace_on,
  input wire logic        ts_request
);
  // same take condition as the slave, so data phases line up
  wire        take   = hsel & htrans[1] & hready & (hsize == 3'h2);
  wire        stim_a = haddr[11:0] <= OFS_STIM_HI;
  wire        rsvd_a = (haddr[11:0] > OFS_STIM_HI) && (haddr[11:0] < OFS_IMPL_LO);
  logic       dp_stim;
  logic [4:0] dp_port;

  // remember which stimulus write sits in its data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_stim <= 1'b0;
      dp_port <= 5'h0;
    end else begin
      dp_stim <= take & hwrite & stim_a;
      dp_port <= haddr[6:2];
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_ready_high: assert property (hreadyout)
    else $error("slave stretched a transfer");
  a_resp_okay: assert property (!hresp)
    else $error("slave answered with an error");
  a_evt_pulse: assert property (stim_evt.valid |=> !stim_evt.valid)
    else $error("event valid longer than one cycle");
  a_evt_cause: assert property (stim_evt.valid |-> $past(dp_stim & sink_ready))
    else $error("event without an accepted stimulus write");
  a_no_evt_unready: assert property (dp_stim && !sink_ready |=> !stim_evt.valid)
    else $error("event while the sink was not ready");
  a_evt_port: assert property (stim_evt.valid |-> stim_evt.port == $past(dp_port))
    else $error("event carries the wrong port");
  a_evt_data: assert property (stim_evt.valid |-> stim_evt.data == $past(hwdata))
    else $error("event carries the wrong data");
  a_rsvd_zero: assert property (take && !hwrite && rsvd_a |=> hrdata == 32'h0)
    else $error("reserved read not zero");
  a_stim_rd_bits: assert property (take && !hwrite && stim_a |=> hrdata[31:1] == 31'h0)
    else $error("stimulus read upper bits not zero");
endmodule : tscb_top_monitor

bind tscb_top tscb_top_monitor tscb_top_monitor_i (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .sink_ready(sink_ready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .stim_evt(stim_evt), .trace_on(trace_on), .ts_request(ts_request));

// file: testbench/tscb_sink_model.sv
`timescale 1ns/10ps
module tscb_sink_model
  import tscb_pkg::*;
(
  input  wire logic      hclk,
  input  wire logic      hresetn,
  input  wire logic      stall_en,
  input  wire tscb_evt_s evt,
  output logic           sink_ready,
  output int             evt_count
);
  logic [7:0] lfsr;

  // pseudo random stalls so full buffering shows up mid traffic
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lfsr       <= 8'hA5;
      sink_ready <= 1'b1;
      evt_count  <= 0;
    end else begin
      lfsr       <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      sink_ready <= !stall_en | lfsr[0];
      if (evt.valid) evt_count <= evt_count + 1;
    end
  end
endmodule : tscb_sink_model

// file: testbench/tb.sv
`timescale 1ns/10ps
module tb;
  import tscb_pkg::*;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, stall_en = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, trace_on, ts_request, sink_ready, sr_ap, sr_dp;
  tscb_evt_s   stim_evt;
  int          evt_count, errors = 0, cmp_count = 0, seed = 32'h60d15feb, exp_evts = 0;
  int          tmask = 0, gmask = 0, ctl = 0, fld = 0, locked = 1;
  int          ctls[5] = '{0, 1, 2, 3, 3};
  int          flds[5] = '{3, 3, 3, 3, 1};

  always #25 hclk = ~hclk;

  tscb_top tscb_top_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .sink_ready(sink_ready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .stim_evt(stim_evt), .trace_on(trace_on), .ts_request(ts_request));

  tscb_sink_model tscb_sink_model_i (
    .hclk(hclk), .hresetn(hresetn), .stall_en(stall_en), .evt(stim_evt),
    .sink_ready(sink_ready), .evt_count(evt_count));

  task report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // one single AHB-Lite word transfer; sink level noted in both phases
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    @(negedge hclk) sr_ap = sink_ready;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    @(negedge hclk) sr_dp = sink_ready;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  // effective masks for group 0, the only group this unit has
  function automatic logic [31:0] eff(input int trig);
    bit g0 = fld != 0 && (fld & (fld - 1)) == 0;
    if (ctl == 3 && !g0) return 32'h0;
    if (trig != 0 && ctl != 0 && !g0) return 32'h0;
    return trig != 0 ? 32'(gmask & tmask) : 32'(tmask);
  endfunction : eff

  // model follows the lock: only the key register and stimulus escape it
  task wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    if (a[11:0] == OFS_UNLOCK) locked = (d != UNLOCK_KEY);
    else if (!locked && a[11:0] == OFS_TRACE_EN) tmask = d;
    else if (!locked && a[11:0] == OFS_TRIG_EN) gmask = d;
    else if (!locked && a[11:0] == OFS_GROUP_SEL) begin
      fld = d[31:20];
      ctl = d[1:0];
    end
  endtask : wr

  task rdchk(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rdchk

  // stimulus write, event check in the following cycle, then ready readback
  task stim(input int k);
    logic [31:0] te, tg, d;
    logic        v;
    d = $random(seed);
    te = eff(0);
    tg = eff(1);
    bus(1'b1, 32'(k * 4), d);
    v = te[k] & sr_dp;
    if (v) exp_evts++;
    @(negedge hclk);
    check({31'h0, stim_evt.valid}, {31'h0, v});
    if (v) begin
      check({27'h0, stim_evt.port}, 32'(k));
      check(stim_evt.data, d);
      check({31'h0, stim_evt.trig}, {31'h0, tg[k]});
    end
    bus(1'b0, 32'(k * 4), 32'h0);
    check(rd, {31'h0, te[k] & sr_ap});
  endtask : stim

  initial begin
    repeat (20000) @(posedge hclk);
    errors++;
    $display("watchdog expired");
    report_and_stop;
  end

  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk(OFS_TRACE_EN, RST_ZERO);
    rdchk(OFS_TRIG_EN, RST_ZERO);
    rdchk(OFS_FEAT2, 32'h3);
    rdchk(OFS_LOCK_STATE, 32'h3);
    wr(OFS_TRACE_EN, 32'hFFFF_FFFF);
    rdchk(OFS_TRACE_EN, RST_ZERO);
    $display("reset and lock test done");
    wr(OFS_UNLOCK, UNLOCK_KEY);
    rdchk(OFS_LOCK_STATE, 32'h1);
    wr(32'h0000_0080, 32'hFFFF_FFFF);
    rdchk(32'h0000_0080, 32'h0);
    wr(32'h0000_0E04, 32'hFFFF_FFFF);
    rdchk(32'h0000_0E04, 32'h0);
    rdchk(32'h0000_0EAC, 32'h0);
    wr(OFS_TRIG_EN, $random(seed) | 1);
    rdchk(OFS_TRIG_EN, gmask);
    wr(OFS_TRACE_EN, $random(seed));
    rdchk(OFS_TRACE_EN, tmask);
    wr(OFS_IMPL_LO, 32'hA5A5_0F0F);
    rdchk(OFS_IMPL_LO, 32'hA5A5_0F0F);
    wr(OFS_TRACE_CSR, 32'h0000_0001);
    @(negedge hclk) check({31'h0, trace_on}, 32'h1);
    wr(OFS_TS_REQ, 32'h0000_0001);
    @(negedge hclk) check({31'h0, ts_request}, 32'h1);
    @(negedge hclk) check({31'h0, ts_request}, 32'h0);
    $display("register test done");
    wr(OFS_UNLOCK, 32'h0);
    rdchk(OFS_LOCK_STATE, 32'h3);
    stall_en <= 1'b1;
    for (int k = 0; k < NUM_PORTS; k++) stim(k);
    $display("locked port walk done");
    wr(OFS_UNLOCK, UNLOCK_KEY);
    wr(OFS_TRACE_EN, 32'h0000_000F);
    for (int i = 0; i < 5; i++) begin
      wr(OFS_GROUP_SEL, {12'(flds[i]), 18'h0, 2'(ctls[i])});
      for (int k = 0; k < 5; k++) stim(k);
    end
    $display("group select test done");
    repeat (2) @(posedge hclk);
    check(32'(evt_count), 32'(exp_evts));
    report_and_stop;
  end
endmodule : tb
